// ===== design/ifb_feature_access.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Pointer and command unlock after code 0xBB
// - Gate register write-only, reads return zero
// - Each feature bit addressed via pointer
// - Command read returns selected bit at 6
// - Bit 7 set writes bit 1 value
// - Pointer holds plain binary bit address
// - Bits 135..132 form reference delay code
// - Bits 139..136 form feedback delay code
// - Bit 143 output zero trim MSB, resets 1
module ifb_feature_access (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [3:0] ref_path_delay_code,
  output logic      [3:0] feedback_path_delay_code,
  output logic      [3:0] output0_drive_trim,
  output logic            ref_delay_code_invalid,
  output logic            feedback_delay_code_invalid,
  output logic            unlocked
);

  logic [ifb_pkg::FEAT_BITS-1:0] feat;
  logic [ifb_pkg::FEAT_BITS-1:0] next_feat;
  logic [7:0]                    pointer;
  logic [7:0]                    next_pointer;
  logic                          next_unlocked;
  logic [7:0]                    next_rdata;
  logic [3:0]                    next_ref_delay;
  logic [3:0]                    next_fb_delay;
  logic [3:0]                    next_trim;
  logic                          next_ref_bad;
  logic                          next_fb_bad;

  always_comb
  begin
    next_unlocked = unlocked;
    next_pointer  = pointer;
    next_feat     = feat;
    next_rdata    = reg_rdata;
    if (reg_wr)
    begin
      if (reg_addr == ifb_pkg::GATE_OFFSET)
      begin
        next_unlocked = (reg_wdata == ifb_pkg::ACCESS_CODE);
      end
      else if (reg_addr == ifb_pkg::POINTER_OFFSET && unlocked)
      begin
        next_pointer = reg_wdata;
      end
      else if (reg_addr == ifb_pkg::COMMAND_OFFSET && unlocked && reg_wdata[ifb_pkg::CMD_WRITE_EN_BIT])
      begin
        next_feat[pointer] = reg_wdata[ifb_pkg::CMD_WRITE_VAL_BIT];
      end
    end
    if (reg_rd)
    begin
      next_rdata = 8'h00;
      if (reg_addr == ifb_pkg::POINTER_OFFSET && unlocked)
      begin
        next_rdata = pointer;
      end
      else if (reg_addr == ifb_pkg::COMMAND_OFFSET && unlocked)
      begin
        next_rdata[ifb_pkg::CMD_READ_VAL_BIT] = feat[pointer];
      end
    end
  end

  always_comb
  begin
    next_ref_delay = next_feat[ifb_pkg::REF_DELAY_LSB +: ifb_pkg::DELAY_CODE_W];
    next_fb_delay  = next_feat[ifb_pkg::FB_DELAY_LSB +: ifb_pkg::DELAY_CODE_W];
    next_trim      = next_feat[ifb_pkg::OUT0_TRIM_LSB +: ifb_pkg::DELAY_CODE_W];
    next_ref_bad   = next_ref_delay > ifb_pkg::DELAY_CODE_MAX;
    next_fb_bad    = next_fb_delay > ifb_pkg::DELAY_CODE_MAX;
  end

  // state held, unlock cleared at reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unlocked                    <= 1'b0;
      pointer                     <= ifb_pkg::POINTER_RESET;
      feat                        <= ifb_pkg::FEAT_RESET;
      reg_rdata                   <= 8'h00;
      ref_path_delay_code         <= 4'h0;
      feedback_path_delay_code    <= 4'h0;
      output0_drive_trim          <= 4'h8;
      ref_delay_code_invalid      <= 1'b0;
      feedback_delay_code_invalid <= 1'b0;
    end
    else
    begin
      unlocked                    <= next_unlocked;
      pointer                     <= next_pointer;
      feat                        <= next_feat;
      reg_rdata                   <= next_rdata;
      ref_path_delay_code         <= next_ref_delay;
      feedback_path_delay_code    <= next_fb_delay;
      output0_drive_trim          <= next_trim;
      ref_delay_code_invalid      <= next_ref_bad;
      feedback_delay_code_invalid <= next_fb_bad;
    end
  end

endmodule

// ===== design/ifb_pkg.sv
package ifb_pkg;
  // Byte offsets on the register interface
  localparam logic [7:0] GATE_OFFSET    = 8'h08;
  localparam logic [7:0] POINTER_OFFSET = 8'h09;
  localparam logic [7:0] COMMAND_OFFSET = 8'h0a;
  // Unlock code
  localparam logic [7:0] ACCESS_CODE    = 8'hbb;
  // Command register fields
  localparam int CMD_WRITE_EN_BIT  = 7;
  localparam int CMD_READ_VAL_BIT  = 6;
  localparam int CMD_WRITE_VAL_BIT = 1;
  // Feature bit map
  localparam int FEAT_BITS          = 256;
  localparam int REF_DELAY_LSB      = 132;
  localparam int FB_DELAY_LSB       = 136;
  localparam int OUT0_TRIM_LSB      = 140;
  localparam int DELAY_CODE_W       = 4;
  localparam logic [3:0] DELAY_CODE_MAX = 4'h9;
  localparam logic [FEAT_BITS-1:0] FEAT_RESET = 256'h0000_0000_0000_0000_0000_0000_0000_8000_0000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic [7:0] POINTER_RESET = 8'h00;
endpackage

// ===== testbench/ifb_assertions.sv
`timescale 1ns/1ns
module ifb_chk(input wire logic core_clk, rst_n, reg_wr, reg_rd, unlocked,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, input wire logic [3:0] output0_drive_trim);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire gw = reg_wr && reg_addr == 8'h08, cw = reg_wr && reg_addr == 8'h0a, cr = reg_rd && reg_addr == 8'h0a;
  gate_rd_a: assert property (reg_rd && reg_addr == 8'h08 |=> !reg_rdata) else $error("gate");
  lock_rd_a: assert property (cr && !unlocked |=> !reg_rdata) else $error("lock");
  cmd_rsvd_a: assert property (cr |=> !(reg_rdata & 8'hbf)) else $error("rsvd");
  unlock_code_a: assert property (gw |=> unlocked == ($past(reg_wdata) == 8'hbb)) else $error("code");
  unlock_hold_a: assert property (!gw |=> $stable(unlocked)) else $error("hold");
  trim_hold_a: assert property (!cw |=> $stable(output0_drive_trim)) else $error("trim");
  lock_wr_a: assert property (cw && !unlocked |=> $stable(output0_drive_trim)) else $error("lkwr");
  no_wen_a: assert property (cw && !reg_wdata[7] |=> $stable(output0_drive_trim)) else $error("wen");
  cover property (gw ##1 unlocked);
  cover property (cw && unlocked);
  cover property (cr && unlocked);
endmodule
bind ifb_feature_access ifb_chk u_chk(.*);

// ===== testbench/ifb_host.sv
`timescale 1ns/1ns
module ifb_host(input wire logic core_clk, input wire logic [7:0] reg_rdata,
  output logic reg_wr = 0, reg_rd = 0, output logic [7:0] reg_addr = 0, reg_wdata = 0);
  // single strobe; idle lines flip so stale values never pass
  task automatic x(input logic wr, input logic [7:0] a, v, output logic [7:0] q);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, v};
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~v};
    q = reg_rdata;
  endtask
endmodule

// ===== testbench/tb_indirect_feature_bit_access.sv
`timescale 1ns/1ns
module tb_indirect_feature_bit_access;
  logic core_clk = 0, rst_n = 0, reg_wr, reg_rd, unlocked, ref_delay_code_invalid, feedback_delay_code_invalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, f = 0;
  logic lk = 0;
  logic [3:0] ref_path_delay_code, feedback_path_delay_code, output0_drive_trim;
  int n_fail, total_checks, p, s;
  initial forever #5 core_clk = ~core_clk;
  ifb_host u_host(.*);
  ifb_feature_access u_dut(.*);
  function automatic logic [19:0] ex(logic [3:0] t, logic b);
    return {t, f, 1'b0, b, 6'h00};
  endfunction
  task cmp(string nm, logic [19:0] g, e);
    total_checks++;
    if (g !== e) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end
    $display("test %0d done", total_checks);
  endtask
  // Unlock expectation follows the gate writes alone
  task w(logic [7:0] a, v);
    if (a == 8'h08) lk = (v == 8'hbb);
    u_host.x(1, a, v, d);
  endtask
  task rd(logic [3:0] t, logic b);
    u_host.x(0, 8'h0a, 0, d);
    cmp("fields", {output0_drive_trim, feedback_path_delay_code, ref_path_delay_code, d}, ex(t, b));
    cmp("flags", {17'h00000, ref_delay_code_invalid, feedback_delay_code_invalid, unlocked},
        {17'h00000, f[3:0] > 4'h9, f[7:4] > 4'h9, lk});
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin repeat (3000) @(posedge core_clk); n_fail++; print_verdict; end
  initial begin
    p = $urandom(32'h9874_6a3b);
    repeat (12) @(negedge core_clk);
    rst_n = 1;
    w(8'h09, 8'h8f);
    w(8'h0a, 8'h80);
    rd(8, 0);
    w(8'h08, 8'hbb);
    w(8'h09, 8'h8f);
    u_host.x(0, 8'h08, 0, d);
    cmp("gate", {12'h000, d}, 20'h0_0000);
    u_host.x(0, 8'h09, 0, d);
    cmp("pointer", {12'h000, d}, 20'h0_008f);
    rd(8, 1);
    w(8'h0a, 8'h80);
    w(8'h0a, 8'h00);
    rd(0, 0);
    repeat (24) begin
      p = $urandom_range(7); s = $urandom_range(1); f[p] = s[0];
      w(8'h09, 8'(132 + p));
      w(8'h0a, {1'b1, 5'($urandom), s[0], 1'($urandom)});
      w(8'h0a, 8'h00);
      rd(0, s[0]);
    end
    // Mid-run reset must relock and restore the field defaults
    @(negedge core_clk);
    rst_n = 0;
    lk = 0;
    f = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    rd(8, 0);
    w(8'h08, 8'hbb);
    w(8'h09, 8'h8f);
    rd(8, 1);
    w(8'h08, 8'h5a);
    rd(8, 0);
    print_verdict;
  end
endmodule
